/* rtl/dhbp_device.sv */
// Operation
// - Select lines pick one host register
// - Access valid only while chip select low
// - Eight-bit bus, host writes, device reads
// - Direction low write, high read
// - Ready low when read data valid
// - Ready low once write byte captured
// - Ready high one cycle, then released
// - Reset sampled synchronously, clock keeps running
module dhbp_device
    import dhbp_pkg::*;
(
    input wire logic i_mclk, // System clock
    input wire logic i_rst_n, // Synchronous reset, low active
    dhbp_if.device bus, // Host port pins
    input wire logic [DHBP_NUM_REGS*DHBP_DATA_W-1:0] i_rd_regs, // Core values per register
    output logic [DHBP_NUM_REGS*DHBP_DATA_W-1:0] o_wr_regs, // Written register values
    output logic o_wr_stb, // One-cycle pulse on capture
    output logic [DHBP_SEL_W-1:0] o_wr_sel, // Register just written
    output logic o_rd_stb, // One-cycle pulse on read
    output logic [DHBP_SEL_W-1:0] o_rd_sel // Register just read
);
    dhbp_dev_state_t state_reg, state_next; // Cycle state
    logic [DHBP_DATA_W-1:0] regs_reg [DHBP_NUM_REGS]; // Host registers
    logic [DHBP_DATA_W-1:0] regs_next [DHBP_NUM_REGS];
    logic [DHBP_DATA_W-1:0] rdata_reg, rdata_next; // Read byte driven out
    logic dout_oe_reg, dout_oe_next; // Bus drive enable
    logic ack_reg, ack_next; // Ack level driven
    logic ack_oe_reg, ack_oe_next; // Ack drive enable
    logic wr_stb_reg, wr_stb_next;
    logic rd_stb_reg, rd_stb_next;
    logic [DHBP_SEL_W-1:0] sel_reg, sel_next; // Select of this cycle

    // Pick one core byte by select
    function automatic logic [DHBP_DATA_W-1:0] pick(
        input logic [DHBP_NUM_REGS*DHBP_DATA_W-1:0] v,
        input logic [DHBP_SEL_W-1:0] s
    );
        pick = v[s*DHBP_DATA_W +: DHBP_DATA_W];
    endfunction

    // Next-state logic of the cycle engine
    always_comb begin
        state_next = state_reg;
        regs_next = regs_reg;
        rdata_next = rdata_reg;
        dout_oe_next = dout_oe_reg;
        ack_next = ack_reg;
        ack_oe_next = ack_oe_reg;
        wr_stb_next = 1'b0;
        rd_stb_next = 1'b0;
        sel_next = sel_reg;
        unique case (state_reg)
            DHBP_DEV_IDLE: begin
                // Inputs are ignored while chip select is high
                if (!bus.host_port_select_n) begin
                    sel_next = bus.host_reg_select;
                    state_next = DHBP_DEV_ACK;
                    ack_next = 1'b0;
                    ack_oe_next = 1'b1;
                    if (bus.host_read_not_write == DHBP_DIR_READ) begin
                        // Reads return the core value; data and ack leave together
                        rdata_next = pick(i_rd_regs, bus.host_reg_select);
                        dout_oe_next = 1'b1;
                        rd_stb_next = 1'b1;
                    end else begin
                        // Byte captured in the same edge that asserts ack
                        regs_next[bus.host_reg_select] = bus.host_byte_bus;
                        wr_stb_next = 1'b1;
                    end
                end
            end
            DHBP_DEV_ACK: begin
                // Hold until host ends the cycle
                if (bus.host_port_select_n) begin
                    dout_oe_next = 1'b0;
                    ack_next = 1'b1;
                    state_next = DHBP_DEV_REL;
                end
            end
            DHBP_DEV_REL: begin
                // One high cycle done; release ack so the pull-up holds it
                ack_oe_next = 1'b0;
                state_next = DHBP_DEV_IDLE;
            end
            default: state_next = DHBP_DEV_IDLE;
        endcase
    end

    // Registers; reset is synchronous so the clock must run during it
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            state_reg <= DHBP_DEV_IDLE;
            for (int i = 0; i < DHBP_NUM_REGS; i++) begin
                regs_reg[i] <= DHBP_REG_RST;
            end
            rdata_reg <= '0;
            dout_oe_reg <= 1'b0;
            ack_reg <= 1'b1;
            ack_oe_reg <= 1'b0;
            wr_stb_reg <= 1'b0;
            rd_stb_reg <= 1'b0;
            sel_reg <= '0;
        end else begin
            state_reg <= state_next;
            regs_reg <= regs_next;
            rdata_reg <= rdata_next;
            dout_oe_reg <= dout_oe_next;
            ack_reg <= ack_next;
            ack_oe_reg <= ack_oe_next;
            wr_stb_reg <= wr_stb_next;
            rd_stb_reg <= rd_stb_next;
            sel_reg <= sel_next;
        end
    end

    // Flatten written registers for the core
    always_comb begin
        for (int i = 0; i < DHBP_NUM_REGS; i++) begin
            o_wr_regs[i*DHBP_DATA_W +: DHBP_DATA_W] = regs_reg[i];
        end
    end

    assign bus.host_byte_bus_d = rdata_reg;
    assign bus.host_byte_bus_d_oe = dout_oe_reg;
    assign bus.host_ack_n_d = ack_reg;
    assign bus.host_ack_n_d_oe = ack_oe_reg;
    assign o_wr_stb = wr_stb_reg;
    assign o_wr_sel = sel_reg;
    assign o_rd_stb = rd_stb_reg;
    assign o_rd_sel = sel_reg;
endmodule

/* rtl/dhbp_host.sv */
// Host end: runs one access per request and waits for ack
module dhbp_host
    import dhbp_pkg::*;
(
    input wire logic i_mclk, // System clock
    input wire logic i_rst_n, // Synchronous reset, low active
    dhbp_if.host bus, // Host port pins
    input wire logic i_req, // Start an access, level
    input wire logic i_rnw, // High read, low write
    input wire logic [DHBP_SEL_W-1:0] i_sel, // Register to reach
    input wire logic [DHBP_DATA_W-1:0] i_wdata, // Byte to write
    output logic o_ready, // Can take a request
    output logic o_done, // One-cycle pulse at cycle end
    output logic [DHBP_DATA_W-1:0] o_rdata // Byte read
);
    dhbp_hst_state_t state_reg, state_next; // Cycle state
    logic cs_n_reg, cs_n_next; // Chip select out
    logic rnw_reg, rnw_next; // Direction out
    logic [DHBP_SEL_W-1:0] sel_reg, sel_next; // Select out
    logic [DHBP_DATA_W-1:0] wd_reg, wd_next; // Write byte out
    logic oe_reg, oe_next; // Bus drive enable
    logic [DHBP_DATA_W-1:0] rd_reg, rd_next; // Captured read byte
    logic done_reg, done_next;

    // Next-state logic
    always_comb begin
        state_next = state_reg;
        cs_n_next = cs_n_reg;
        rnw_next = rnw_reg;
        sel_next = sel_reg;
        wd_next = wd_reg;
        oe_next = oe_reg;
        rd_next = rd_reg;
        done_next = 1'b0;
        unique case (state_reg)
            DHBP_HST_IDLE: begin
                // Drive everything together with chip select
                if (i_req) begin
                    cs_n_next = 1'b0;
                    sel_next = i_sel;
                    rnw_next = i_rnw ? DHBP_DIR_READ : DHBP_DIR_WRITE;
                    wd_next = i_wdata;
                    oe_next = !i_rnw;
                    state_next = DHBP_HST_WAIT;
                end
            end
            DHBP_HST_WAIT: begin
                // Inputs held stable until ack low
                if (!bus.host_ack_n) begin
                    if (rnw_reg == DHBP_DIR_READ) begin
                        rd_next = bus.host_byte_bus;
                    end
                    cs_n_next = 1'b1;
                    oe_next = 1'b0;
                    state_next = DHBP_HST_END;
                end
            end
            DHBP_HST_END: begin
                // Wait for the device to let ack rise before a new cycle
                if (bus.host_ack_n) begin
                    done_next = 1'b1;
                    state_next = DHBP_HST_IDLE;
                end
            end
            default: state_next = DHBP_HST_IDLE;
        endcase
    end

    // Registers
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            state_reg <= DHBP_HST_IDLE;
            cs_n_reg <= 1'b1;
            rnw_reg <= DHBP_DIR_READ;
            sel_reg <= '0;
            wd_reg <= '0;
            oe_reg <= 1'b0;
            rd_reg <= '0;
            done_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cs_n_reg <= cs_n_next;
            rnw_reg <= rnw_next;
            sel_reg <= sel_next;
            wd_reg <= wd_next;
            oe_reg <= oe_next;
            rd_reg <= rd_next;
            done_reg <= done_next;
        end
    end

    assign bus.host_port_select_n = cs_n_reg;
    assign bus.host_read_not_write = rnw_reg;
    assign bus.host_reg_select = sel_reg;
    assign bus.host_byte_bus_h = wd_reg;
    assign bus.host_byte_bus_h_oe = oe_reg;
    assign o_ready = (state_reg == DHBP_HST_IDLE);
    assign o_done = done_reg;
    assign o_rdata = rd_reg;
endmodule

/* rtl/dhbp_if.sv */
// Pins between host and device; ack and data are resolved here
interface dhbp_if;
    import dhbp_pkg::*;
    logic [DHBP_SEL_W-1:0] host_reg_select; // Register select
    logic host_port_select_n; // Chip select, low active
    logic host_read_not_write; // High read, low write
    logic [DHBP_DATA_W-1:0] host_byte_bus_h; // Host drive value
    logic host_byte_bus_h_oe; // Host drives bus
    logic [DHBP_DATA_W-1:0] host_byte_bus_d; // Device drive value
    logic host_byte_bus_d_oe; // Device drives bus
    logic host_ack_n_d; // Device ack drive value
    logic host_ack_n_d_oe; // Device drives ack
    logic [DHBP_DATA_W-1:0] host_byte_bus; // Resolved bus level
    logic host_ack_n; // Resolved ack, pulled up when released

    // Idle bus reads as zero; pull-up keeps ack high
    assign host_byte_bus = host_byte_bus_d_oe ? host_byte_bus_d :
                           (host_byte_bus_h_oe ? host_byte_bus_h : '0);
    assign host_ack_n = host_ack_n_d_oe ? host_ack_n_d : 1'b1;

    modport device (
        input host_reg_select, host_port_select_n, host_read_not_write, host_byte_bus,
        output host_byte_bus_d, host_byte_bus_d_oe, host_ack_n_d, host_ack_n_d_oe
    );
    modport host (
        output host_reg_select, host_port_select_n, host_read_not_write,
        output host_byte_bus_h, host_byte_bus_h_oe,
        input host_byte_bus, host_ack_n
    );
endinterface

/* rtl/dhbp_pkg.sv */
package dhbp_pkg;
    // Width of the host byte bus
    localparam int unsigned DHBP_DATA_W = 8;
    // Width of the register select
    localparam int unsigned DHBP_SEL_W = 2;
    // Number of host registers reachable by the select
    localparam int unsigned DHBP_NUM_REGS = 4;
    // Reset value of every host register
    localparam logic [7:0] DHBP_REG_RST = 8'h00;
    // Cycles the device drives ready high before release
    localparam int unsigned DHBP_REL_CYCLES = 1;
    // Direction line levels
    localparam logic DHBP_DIR_WRITE = 1'b0;
    localparam logic DHBP_DIR_READ = 1'b1;

    // Device end cycle states
    typedef enum logic [1:0] {
        DHBP_DEV_IDLE,
        DHBP_DEV_ACK,
        DHBP_DEV_REL
    } dhbp_dev_state_t;

    // Host end cycle states
    typedef enum logic [1:0] {
        DHBP_HST_IDLE,
        DHBP_HST_WAIT,
        DHBP_HST_END
    } dhbp_hst_state_t;
endpackage

/* tb/dhbp_sva.sv */
// Pin checker beside the interface joining host and device
module dhbp_sva
    import dhbp_pkg::*;
(
    input wire logic i_mclk, // System clock
    input wire logic i_rst_n, // Sync reset, low active
    input wire logic host_port_select_n, // Chip select
    input wire logic host_read_not_write, // Direction
    input wire logic host_byte_bus_d_oe, // Device drives data
    input wire logic host_ack_n_d, // Device ack value
    input wire logic host_ack_n_d_oe, // Device drives ack
    input wire logic host_ack_n // Resolved ack
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    ack_after_take_a: assert property (
        $fell(host_port_select_n) |=> !host_ack_n) else $error("ack late after select");
    ack_holds_a: assert property (
        !host_ack_n && !host_port_select_n |=> !host_ack_n) else $error("ack dropped early");
    ack_high_once_a: assert property (
        !host_ack_n && $rose(host_port_select_n) |=> host_ack_n_d_oe && host_ack_n_d
        ##1 !host_ack_n_d_oe) else $error("ack not high one cycle then released");
    ack_cause_a: assert property (
        $fell(host_ack_n) |-> !$past(host_port_select_n)) else $error("ack without select");
    read_drive_a: assert property (
        !host_ack_n && host_read_not_write |-> host_byte_bus_d_oe) else $error("read undriven");
    write_quiet_a: assert property (
        !host_port_select_n && !host_read_not_write |-> !host_byte_bus_d_oe)
        else $error("device drives in write");
    idle_release_a: assert property (
        host_port_select_n [*3] |-> !host_ack_n_d_oe && !host_byte_bus_d_oe)
        else $error("pins driven while idle");
    // Own disable: this one must look through reset
    reset_quiet_a: assert property (disable iff (1'b0)
        !i_rst_n |=> !host_ack_n_d_oe && !host_byte_bus_d_oe) else $error("pins driven in reset");
endmodule

/* tb/tb_top.sv */
module tb_top
    import dhbp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_mclk = 1'b0; // System clock
    logic i_rst_n = 1'b0; // Sync reset
    logic i_req = 1'b0; // Host request
    logic i_rnw = 1'b0; // Host direction
    logic [1:0] i_sel = 2'h0; // Host select
    logic [7:0] i_wdata = 8'h00; // Host write byte
    logic [31:0] i_rd_regs = 32'hc3a5_5a3c; // Core bytes, all distinct
    logic o_ready, o_done, o_wr_stb, o_rd_stb; // Handshakes
    logic [7:0] o_rdata; // Byte read
    logic [1:0] o_wr_sel, o_rd_sel; // Strobed selects
    logic [31:0] o_wr_regs, wr_regs_b; // Stored registers
    logic [31:0] exp_regs = 32'h0; // Expected store
    int n_errors = 0;
    int n_tests = 0;
    dhbp_if bus_a(); // Host to device
    dhbp_if bus_b(); // Bench to second device
    always #5 i_mclk = ~i_mclk;
    dhbp_device dhbp_device_i(.i_mclk, .i_rst_n, .bus(bus_a), .i_rd_regs, .o_wr_regs,
        .o_wr_stb, .o_wr_sel, .o_rd_stb, .o_rd_sel);
    // Second device: bench breaks the host's side on purpose
    dhbp_device dhbp_device_i2(.i_mclk, .i_rst_n, .bus(bus_b), .i_rd_regs,
        .o_wr_regs(wr_regs_b), .o_wr_stb(), .o_wr_sel(), .o_rd_stb(), .o_rd_sel());
    dhbp_host dhbp_host_i(.i_mclk, .i_rst_n, .bus(bus_a), .i_req, .i_rnw, .i_sel,
        .i_wdata, .o_ready, .o_done, .o_rdata);
    dhbp_sva dhbp_sva_i(.i_mclk, .i_rst_n, .host_port_select_n(bus_a.host_port_select_n),
        .host_read_not_write(bus_a.host_read_not_write),
        .host_byte_bus_d_oe(bus_a.host_byte_bus_d_oe), .host_ack_n_d(bus_a.host_ack_n_d),
        .host_ack_n_d_oe(bus_a.host_ack_n_d_oe), .host_ack_n(bus_a.host_ack_n));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // One access through the host end, watching the pins as it runs
    task automatic access(input logic rnw, input logic [1:0] sel, input logic [7:0] wd);
        logic [2:0] stb = 3'h0;
        logic [7:0] seen = 8'h00;
        int highs = 0;
        chk(o_ready, 1, "ready before request");
        i_req <= 1'b1;
        i_rnw <= rnw;
        i_sel <= sel;
        i_wdata <= wd;
        @(posedge i_mclk);
        i_req <= 1'b0;
        for (int k = 0; k < 20; k++) begin
            @(posedge i_mclk);
            if ((rnw ? o_rd_stb : o_wr_stb) === 1'b1) begin // Strobe names register
                stb = {1'b1, rnw ? o_rd_sel : o_wr_sel};
            end
            // Byte on wire while acked and still selected; host lets go once deselected
            if (bus_a.host_ack_n === 1'b0 && bus_a.host_port_select_n === 1'b0) begin
                seen = bus_a.host_byte_bus;
            end
            if (bus_a.host_ack_n_d_oe === 1'b1 && bus_a.host_ack_n_d === 1'b1) begin
                highs++;
            end
            if (o_done === 1'b1) break;
        end
        chk(o_done, 1, "done");
        chk(stb, {1'b1, sel}, "strobe select");
        chk(seen, rnw ? i_rd_regs[8*sel +: 8] : wd, "wire byte");
        chk(highs, 1, "ack high cycles");
    endtask
    // All four registers written, then read back to back
    task automatic write_read_all();
        for (int s = 0; s < 4; s++) begin
            access(DHBP_DIR_WRITE, 2'(s), 8'h81 + 8'(s) * 8'h22);
            exp_regs[8*s +: 8] = 8'h81 + 8'(s) * 8'h22;
            chk(o_wr_regs, exp_regs, "stored");
        end
        for (int s = 3; s >= 0; s--) begin
            access(DHBP_DIR_READ, 2'(s), 8'hff);
            chk(o_rdata, i_rd_regs[8*s +: 8], "read byte");
            chk(o_wr_regs, exp_regs, "read kept store");
        end
    endtask
    // Reset lands while the device holds ack low
    task automatic reset_mid();
        i_req <= 1'b1;
        i_rnw <= DHBP_DIR_WRITE;
        for (int k = 0; k < 10 && bus_a.host_ack_n !== 1'b0; k++) @(posedge i_mclk);
        i_req <= 1'b0;
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_mclk);
        chk(bus_a.host_ack_n_d_oe, 0, "ack released");
        chk({o_wr_regs, bus_a.host_port_select_n}, 33'h1, "reset state");
        i_rst_n <= 1'b1;
        @(posedge i_mclk);
    endtask
    // Inputs ignored while deselected, and changes ignored while acked
    task automatic stray_inputs();
        bus_b.host_byte_bus_h_oe <= 1'b1;
        repeat (4) @(posedge i_mclk);
        chk({wr_regs_b, bus_b.host_ack_n_d_oe}, 33'h0, "deselected");
        bus_b.host_port_select_n <= 1'b0;
        for (int k = 0; k < 10 && bus_b.host_ack_n !== 1'b0; k++) @(posedge i_mclk);
        bus_b.host_reg_select <= 2'h1; // Broken hold while acked
        bus_b.host_byte_bus_h <= 8'h69;
        repeat (2) @(posedge i_mclk);
        bus_b.host_port_select_n <= 1'b1;
        bus_b.host_byte_bus_h_oe <= 1'b0;
        repeat (4) @(posedge i_mclk);
        chk(wr_regs_b, 32'h0096_0000, "first byte kept");
        chk(bus_b.host_ack_n, 1, "ack released");
    endtask
    task automatic print_verdict();
        $display("errors %0d tests %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Watchdog: whole run needs under a hundred cycles
    initial begin
        #20000;
        n_errors++;
        print_verdict();
    end
    initial begin
        bus_b.host_port_select_n = 1'b1; // Bench side of second port idle
        bus_b.host_read_not_write = DHBP_DIR_WRITE;
        bus_b.host_reg_select = 2'h2;
        bus_b.host_byte_bus_h = 8'h96;
        bus_b.host_byte_bus_h_oe = 1'b0;
        repeat (2) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        @(posedge i_mclk);
        write_read_all();
        reset_mid();
        stray_inputs();
        print_verdict();
    end
endmodule
